/* File: logic/system_error_defs.vh */
`ifndef SYSTEM_ERROR_DEFS_VH
`define SYSTEM_ERROR_DEFS_VH
// ----------------------------------------
// error codes, four hex digits
// ----------------------------------------
`define CODE_NONE 16'h0000
`define CODE_HOST_FAULT 16'h0009
`define CODE_PENDANT_DECEL 16'h000a
`define CODE_SETUP 16'h000b
`define CODE_DATA 16'h000c
`define CODE_LOG_CORRUPT 16'h000d
// ----------------------------------------
// stop types and error bit positions
// ----------------------------------------
`define STOP_NONE 2'h0
`define STOP_DECEL 2'h1
`define STOP_EMERG 2'h2
`define ERR_HOST 0
`define ERR_PENDANT 1
`define ERR_SETUP 2
`define ERR_DATA 3
`define ERR_LOG 4
`define ERR_COUNT 5
`define LOG_DEPTH 16
`define LOG_ADDR_W 4
`endif

/* File: logic/error_log_mem.v */
`include "system_error_defs.vh"
module error_log_mem #(
   parameter DEPTH = `LOG_DEPTH,
   parameter AW = `LOG_ADDR_W
) (
   input wire ref_clk,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [15:0] wr_data,
   input wire [AW-1:0] rd_addr,
   output reg [15:0] rd_data_q
);
   reg [15:0] mem [0:DEPTH-1];
   always @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_q <= mem[rd_addr];
   end
endmodule

/* File: logic/system_error_handler.v */
// How it works
// RQ1: host fault raises 0009, emergency stop
// RQ2: host fault cleared only by restart/power
// RQ3: pendant key raises 000A, pendant_decel_request
// RQ4: reset clears pendant error; re-raises if held
// RQ5: new parameters download raises 000B, decel
// RQ6: old parameters stay until power cycle
// RQ7: corrupted block-read data raises 000C, decel
// RQ8: power-on log check; corrupt raises 000D
// RQ9: corrupt log is wiped entirely
// RQ10: log error cleared by reset/restart/power
// RQ11: codes reported as four hex digits
// RQ12: last code held; stop type same cycle
`include "system_error_defs.vh"
module system_error_handler #(
   parameter AW = `LOG_ADDR_W,
   parameter DEPTH = `LOG_DEPTH,
   parameter PW = 16
) (
   input wire ref_clk,
   input wire rst_n,
   input wire host_fault,
   input wire host_restart,
   input wire pendant_decel_request,
   input wire error_reset,
   input wire param_download,
   input wire [PW-1:0] param_new,
   input wire host_block_read,
   input wire block_data_bad,
   input wire log_check_bad,
   input wire [AW-1:0] log_rd_addr,
   output reg [15:0] error_code_q,
   output reg [1:0] stop_type_q,
   output reg [`ERR_COUNT-1:0] error_active_q,
   output reg [PW-1:0] param_active_q,
   output reg log_init_busy_q,
   output wire [15:0] log_rd_data_q
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   reg [6:0] s1_q, s2_q;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 7'h00;
         s2_q <= 7'h00;
      end else begin
         s1_q <= {log_check_bad, block_data_bad, host_block_read, param_download,
                  error_reset, pendant_decel_request, host_fault};
         s2_q <= s1_q;
      end
   end
   wire fault_s = s2_q[0];
   wire pend_s = s2_q[1];
   wire rst_s = s2_q[2];
   wire dl_s = s2_q[3];
   wire rd_s = s2_q[4];
   wire bad_s = s2_q[5];
   wire log_bad_s = s2_q[6];
   reg restart_s1_q, restart_s2_q, rst_prev_q, dl_prev_q, restart_prev_q;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         restart_s1_q <= 1'b0;
         restart_s2_q <= 1'b0;
         rst_prev_q <= 1'b0;
         dl_prev_q <= 1'b0;
         restart_prev_q <= 1'b0;
      end else begin
         restart_s1_q <= host_restart;
         restart_s2_q <= restart_s1_q;
         rst_prev_q <= rst_s;
         dl_prev_q <= dl_s;
         restart_prev_q <= restart_s2_q;
      end
   end
   wire reset_pulse = rst_s & ~rst_prev_q;
   wire restart_pulse = restart_s2_q & ~restart_prev_q;
   wire dl_pulse = dl_s & ~dl_prev_q;
   // ----------------------------------------
   // power-on log check, one shot after reset release
   // ----------------------------------------
   reg [1:0] settle_q;
   reg [AW:0] wipe_cnt_q;
   // the check waits for the synchroniser to fill; earlier it sees only reset zeros
   wire log_event = (settle_q == 2'h2) & log_bad_s; // RQ8
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_q <= 2'h0;
         log_init_busy_q <= 1'b0;
         wipe_cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (settle_q != 2'h3) begin
            settle_q <= settle_q + 2'h1;
         end
         if (log_event) begin
            log_init_busy_q <= 1'b1; // RQ9
            wipe_cnt_q <= {(AW+1){1'b0}};
         end else if (log_init_busy_q) begin
            wipe_cnt_q <= wipe_cnt_q + {{AW{1'b0}}, 1'b1};
            if (wipe_cnt_q == DEPTH - 1) begin
               log_init_busy_q <= 1'b0;
            end
         end
      end
   end
   // ----------------------------------------
   // parameter sets: staged value waits for power cycle
   // ----------------------------------------
   // stored copy has no reset so it outlives a power cycle, as flash would
   reg [PW-1:0] param_stored_q = {PW{1'b0}};
   reg param_loaded_q;
   always @(posedge ref_clk) begin
      if (dl_pulse) begin
         param_stored_q <= param_new; // RQ6
      end
   end
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         param_active_q <= {PW{1'b0}};
         param_loaded_q <= 1'b0;
      end else begin
         if (!param_loaded_q) begin
            param_active_q <= param_stored_q; // RQ6
            param_loaded_q <= 1'b1;
         end
      end
   end
   // ----------------------------------------
   // error flags: set wins over clear
   // ----------------------------------------
   wire [`ERR_COUNT-1:0] set_v;
   wire [`ERR_COUNT-1:0] clr_v;
   assign set_v[`ERR_HOST] = fault_s; // RQ1
   assign set_v[`ERR_PENDANT] = pend_s; // RQ3 RQ4
   assign set_v[`ERR_SETUP] = dl_pulse; // RQ5
   assign set_v[`ERR_DATA] = rd_s & bad_s; // RQ7
   assign set_v[`ERR_LOG] = log_event;
   assign clr_v[`ERR_HOST] = restart_pulse; // RQ2
   assign clr_v[`ERR_PENDANT] = reset_pulse;
   assign clr_v[`ERR_SETUP] = reset_pulse;
   assign clr_v[`ERR_DATA] = reset_pulse;
   assign clr_v[`ERR_LOG] = reset_pulse | restart_pulse; // RQ10
   genvar gi;
   generate
      for (gi = 0; gi < `ERR_COUNT; gi = gi + 1) begin : g_flag
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               error_active_q[gi] <= 1'b0;
            end else if (set_v[gi]) begin
               error_active_q[gi] <= 1'b1;
            end else if (clr_v[gi]) begin
               error_active_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // code and stop type
   // ----------------------------------------
   wire [`ERR_COUNT-1:0] rise = set_v & ~error_active_q;
   wire [`ERR_COUNT-1:0] next_act = set_v | (error_active_q & ~clr_v);
   reg [15:0] code_d;
   reg [1:0] stop_d;
   always @* begin
      code_d = error_code_q;
      // lowest code wins when several rise together
      if (rise[`ERR_HOST]) begin
         code_d = `CODE_HOST_FAULT; // RQ11
      end else if (rise[`ERR_PENDANT]) begin
         code_d = `CODE_PENDANT_DECEL;
      end else if (rise[`ERR_SETUP]) begin
         code_d = `CODE_SETUP;
      end else if (rise[`ERR_DATA]) begin
         code_d = `CODE_DATA;
      end else if (rise[`ERR_LOG]) begin
         code_d = `CODE_LOG_CORRUPT;
      end else if (next_act == {`ERR_COUNT{1'b0}}) begin
         code_d = `CODE_NONE;
      end
      if (next_act[`ERR_HOST]) begin
         stop_d = `STOP_EMERG; // RQ1
      end else if (next_act != {`ERR_COUNT{1'b0}}) begin
         stop_d = `STOP_DECEL;
      end else begin
         stop_d = `STOP_NONE;
      end
   end
   // code and stop both register from the same set term, so a raise moves them in the same cycle
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         error_code_q <= `CODE_NONE;
         stop_type_q <= `STOP_NONE;
      end else begin
         error_code_q <= code_d; // RQ12
         stop_type_q <= stop_d; // RQ12
      end
   end
   // ----------------------------------------
   // error log: records the winning code of each raise outside a wipe, wiped when corrupt
   // ----------------------------------------
   reg [AW-1:0] log_ptr_q;
   wire any_rise = |rise;
   wire log_we = log_init_busy_q | any_rise;
   wire [AW-1:0] log_wa = log_init_busy_q ? wipe_cnt_q[AW-1:0] : log_ptr_q;
   wire [15:0] log_wd = log_init_busy_q ? `CODE_NONE : code_d;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         log_ptr_q <= {AW{1'b0}};
      end else if (log_init_busy_q) begin
         log_ptr_q <= {AW{1'b0}}; // RQ9
      end else if (any_rise) begin
         log_ptr_q <= log_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
   end
   error_log_mem #(.DEPTH(DEPTH), .AW(AW)) u_log (
      .ref_clk(ref_clk),
      .wr_en(log_we),
      .wr_addr(log_wa),
      .wr_data(log_wd),
      .rd_addr(log_rd_addr),
      .rd_data_q(log_rd_data_q)
   );
endmodule

/* File: test/host_ctrl_model.sv */
// ----------------------------------------
// host controller: registers its commands onto the backplane lines
// ----------------------------------------
module host_ctrl_model (
   input wire logic ref_clk,
   input wire logic fault_cmd,
   input wire logic restart_cmd,
   output logic host_fault,
   output logic host_restart
);
   timeunit 1ns;
   timeprecision 1ps;
   initial host_fault = 1'b0;
   initial host_restart = 1'b0;
   always @(posedge ref_clk) begin
      host_fault <= fault_cmd;
      host_restart <= restart_cmd;
   end
endmodule

/* File: test/seh_properties.sv */
// ----------------------------------------
// checker on the handler ports
// ----------------------------------------
module seh_props (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic host_restart,
   input wire logic pendant_decel_request,
   input wire logic host_block_read,
   input wire logic block_data_bad,
   input wire logic [15:0] error_code_q,
   input wire logic [1:0] stop_type_q,
   input wire logic [4:0] error_active_q,
   input wire logic [15:0] param_active_q,
   input wire logic log_init_busy_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] up_q;
   // cycles since reset; guards the sync pipeline start-up
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) up_q <= 4'h0;
      else if (up_q != 4'hf) up_q <= up_q + 4'h1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   host_code_a: assert property ($rose(error_active_q[0]) |-> error_code_q == 16'h0009)
      else $error("host fault code wrong");
   emerg_stop_a: assert property (error_active_q[0] |-> stop_type_q == 2'h2)
      else $error("host fault not emergency");
   host_sticky_a: assert property (
      up_q == 4'hf && error_active_q[0] && !host_restart
      && !$past(host_restart) && !$past(host_restart, 2) |=> error_active_q[0])
      else $error("host fault dropped");
   pendant_raise_a: assert property (
      up_q == 4'hf && pendant_decel_request [*4] |=> error_active_q[1])
      else $error("pendant key not flagged");
   pendant_decel_request_a: assert property (
      error_active_q != 5'h00 && !error_active_q[0] |-> stop_type_q == 2'h1)
      else $error("pendant_decel_request missing");
   data_gate_a: assert property (
      $rose(error_active_q[3]) |-> $past(host_block_read, 3) && $past(block_data_bad, 3))
      else $error("data error without bad block read");
   param_hold_a: assert property (up_q == 4'hf |=> $stable(param_active_q))
      else $error("active parameters changed");
   code_idle_a: assert property (
      error_active_q == 5'h00 |-> error_code_q == 16'h0000 && stop_type_q == 2'h0)
      else $error("code or stop without error");
   log_wipe_a: assert property ($rose(log_init_busy_q) |-> ##[0:4] error_active_q[4])
      else $error("log wipe without log error");
   cover property ($rose(error_active_q[0]));
   cover property ($rose(error_active_q[1]));
   cover property ($fell(log_init_busy_q));
endmodule
bind system_error_handler seh_props seh_props_inst (.*);

/* File: test/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] drv = 7'h00;
   logic log_bad = 1'b0;
   logic [3:0] raddr = 4'h0;
   logic host_fault, host_restart, busy;
   logic [15:0] code, pact, rdata;
   logic [1:0] stop;
   logic [4:0] act;
   logic [22:0] rows [0:2];
   integer mismatches = 0;
   integer n_tests = 0;
   integer i;
   initial forever #20 ref_clk = ~ref_clk;
   host_ctrl_model host_ctrl_model_inst (.ref_clk(ref_clk), .fault_cmd(drv[0]),
      .restart_cmd(drv[1]), .host_fault(host_fault), .host_restart(host_restart));
   system_error_handler system_error_handler_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .host_fault(host_fault), .host_restart(host_restart),
      .pendant_decel_request(drv[2]), .error_reset(drv[3]), .param_download(drv[4]),
      .param_new(16'hbeef), .host_block_read(drv[5]), .block_data_bad(drv[6]),
      .log_check_bad(log_bad), .log_rd_addr(raddr), .error_code_q(code),
      .stop_type_q(stop), .error_active_q(act), .param_active_q(pact),
      .log_init_busy_q(busy), .log_rd_data_q(rdata));
   task finish_test;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch %s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task apply(input logic [6:0] v);
      begin
         @(posedge ref_clk) drv <= v;
         repeat (6) @(posedge ref_clk);
         #1;
      end
   endtask
   // power cycle; a bad log starts the wipe, which must end in bounded time
   task do_reset(input logic bad);
      integer k;
      begin
         @(posedge ref_clk) log_bad <= bad;
         rst_n <= 1'b0;
         repeat (12) @(posedge ref_clk);
         rst_n <= 1'b1;
         repeat (6) @(posedge ref_clk);
         for (k = 0; k < 64 && busy !== 1'b0; k = k + 1) @(posedge ref_clk);
         #1;
         if (k == 64) begin
            mismatches = mismatches + 1;
            finish_test;
         end
      end
   endtask
   initial begin
      rows[0] = {7'h04, 16'h000a};
      rows[1] = {7'h10, 16'h000b};
      rows[2] = {7'h60, 16'h000c};
      do_reset(1'b0);
      for (i = 0; i < 3; i = i + 1) begin
         apply(rows[i][22:16]);
         apply(7'h00);
         chk("code", rows[i][15:0], code);
         chk("stop", 16'h0001, {14'h0, stop});
         apply(7'h08);
         apply(7'h00);
         chk("flags", 16'h0000, {11'h0, act});
      end
      chk("param", 16'h0000, pact);
      apply(7'h40);
      apply(7'h00);
      chk("flags", 16'h0000, {11'h0, act});
      apply(7'h04);
      apply(7'h0c);
      apply(7'h04);
      chk("flags", 16'h0002, {11'h0, act});
      apply(7'h00);
      apply(7'h08);
      apply(7'h00);
      apply(7'h01);
      chk("code", 16'h0009, code);
      chk("stop", 16'h0002, {14'h0, stop});
      apply(7'h00);
      apply(7'h08);
      apply(7'h00);
      chk("flags", 16'h0001, {11'h0, act});
      apply(7'h02);
      apply(7'h00);
      chk("flags", 16'h0000, {11'h0, act});
      do_reset(1'b1);
      chk("code", 16'h000d, code);
      chk("flags", 16'h0010, {11'h0, act});
      chk("param", 16'hbeef, pact);
      for (i = 1; i < 5; i = i + 1) begin
         @(posedge ref_clk) raddr <= i[3:0];
         repeat (2) @(posedge ref_clk);
         #1;
         chk("log", 16'h0000, rdata);
      end
      apply(7'h08);
      apply(7'h00);
      chk("flags", 16'h0000, {11'h0, act});
      do_reset(1'b1);
      log_bad <= 1'b0;
      chk("flags", 16'h0010, {11'h0, act});
      apply(7'h02);
      apply(7'h00);
      chk("flags", 16'h0000, {11'h0, act});
      do_reset(1'b1);
      do_reset(1'b0);
      chk("flags", 16'h0000, {11'h0, act});
      finish_test;
   end
endmodule
